// ==== dram_seq_pkg.sv ====
// Shared constants and carrier types for the DRAM access and refresh sequencer
package dram_seq_pkg;

  // Depth of every pin synchroniser
  localparam int SYNC_STAGES = 2;

  // Pin inputs after polarity correction, all active high
  typedef struct packed {
    logic cs;           // Chip select asserted
    logic as;           // Address strobe asserted
    logic refresh_req;  // Refresh request from the controller
    logic byte_strobe;  // Upper or lower data strobe asserted
    logic rd;           // High for a read, low for a write
    logic hre;          // Hidden refresh enabled
    logic clk_phase;    // Processor clock phase level
    logic wait_req;     // Wait insertion requested
    logic reg_clk;      // Register clock level
  } pins_type;

  // Registered refresh mode and delay chain, stored active low
  typedef struct packed {
    logic mode_n;
    logic d2_n;
    logic d3_n;
    logic d4_n;
  } chain_type;

  localparam int PINS_W = $bits(pins_type);
  localparam logic [PINS_W-1:0] PINS_IDLE = 9'h000;
  localparam logic [3:0] CHAIN_RST = 4'hf;
  localparam logic OUT_IDLE_N = 1'b1;
  localparam logic [1:0] RST_PIPE_RST = 2'h0;

endpackage

// ==== pin_sync.sv ====
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
module pin_sync
  import dram_seq_pkg::*;
#(
  parameter int WIDTH = PINS_W,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input wire logic mclk_i,             // System clock
  input wire logic rst_n_i,            // Synchronised reset, active low
  input wire logic [WIDTH-1:0] d_i,    // Asynchronous levels
  output logic [WIDTH-1:0] q_o         // Levels in the clock domain
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= IDLE;
      sync_q <= IDLE;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;

endmodule

// ==== delay_chain.sv ====
// Refresh mode register and three-stage delay chain, stepped by register clock
`timescale 1ns/1ps
module delay_chain
  import dram_seq_pkg::*;
(
  input wire logic mclk_i,          // System clock
  input wire logic rst_n_i,         // Synchronised reset, active low
  input wire logic tick_i,          // Register clock rising edge seen
  input wire pins_type pins_i,      // Synchronised pins
  input wire logic row_req_i,       // Row strobe request, active high
  input wire logic cyc_i,           // Cycle done, active high
  input wire logic in_refresh_i,    // Access during refresh, active high
  output chain_type chain_o         // Mode and delay stages, active low
);

  chain_type chain_q;
  chain_type chain_d;
  logic mode;
  logic d2;
  logic d3;
  logic d4;
  logic mode_nx;
  logic d2_nx;
  logic d3_nx;
  logic d4_nx;
  logic forced_start;

  always_comb begin
    mode = ~chain_q.mode_n;
    d2 = ~chain_q.d2_n;
    d3 = ~chain_q.d3_n;
    d4 = ~chain_q.d4_n;
    // Refresh during a long access to some other device
    forced_start = ~pins_i.cs & pins_i.refresh_req & pins_i.as & cyc_i &
                   ~d2 & ~d3 & ~row_req_i; // R13
    mode_nx = (pins_i.refresh_req & ~pins_i.as & ~cyc_i & ~row_req_i) | // R12
              forced_start | // R13
              (mode & ~d3) | (mode & ~d4); // R12
    d2_nx = (mode & ~d4) | // R14
            (pins_i.as & ~cyc_i & ~mode & ~d3 & d4 &
             (~in_refresh_i | pins_i.cs)) | // R14
            (~mode & d2 & ~d3) | // R14
            (pins_i.cs & pins_i.wait_req & pins_i.as & ~mode & d2 & d3 &
             ~d4) | // R14
            (pins_i.cs & pins_i.as & ~pins_i.rd & cyc_i & ~mode &
             ~d2 & ~d3 & ~d4); // R11
    d3_nx = d2 & ~d4; // R15
    // Forced refresh start parks stage c so stage a stays off for one register clock step
    d4_nx = d3 | (~pins_i.as & ~mode) | (forced_start & ~mode); // R15
    chain_d = chain_q;
    if (tick_i) begin // R18
      chain_d = '{mode_n: ~mode_nx, d2_n: ~d2_nx,
                  d3_n: ~d3_nx, d4_n: ~d4_nx};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chain_q <= CHAIN_RST;
    end else begin
      chain_q <= chain_d;
    end
  end

  assign chain_o = chain_q;

  a_stage_b_follow: assert property ( // R15
    @(posedge mclk_i) disable iff (!rst_n_i)
    tick_i |=> (chain_q.d3_n == ~($past(d2) & ~$past(d4))))
    else $error("delay stage b did not follow stage a");

  a_chain_still: assert property ( // R18
    @(posedge mclk_i) disable iff (!rst_n_i)
    !tick_i |=> $stable(chain_q))
    else $error("delay chain moved without a register clock edge");

  a_mode_hold: assert property ( // R12
    @(posedge mclk_i) disable iff (!rst_n_i)
    (tick_i && mode && !d3) |=> !chain_q.mode_n)
    else $error("refresh mode dropped before stage b set");

  a_test_set_restart: assert property ( // R11
    @(posedge mclk_i) disable iff (!rst_n_i)
    (tick_i && pins_i.cs && pins_i.as && !pins_i.rd && cyc_i && !mode &&
     !d2 && !d3 && !d4) |=> !chain_q.d2_n)
    else $error("second stage a pulse missing for test and set");

  a_forced_entry: assert property ( // R13
    @(posedge mclk_i) disable iff (!rst_n_i)
    (tick_i && forced_start) |=> !chain_q.mode_n)
    else $error("refresh mode not entered during long access");

  a_stage_a_refresh: assert property ( // R14
    @(posedge mclk_i) disable iff (!rst_n_i)
    (tick_i && mode && !d4) |=> !chain_q.d2_n)
    else $error("stage a not set during refresh mode");

  a_stage_c_idle: assert property ( // R15
    @(posedge mclk_i) disable iff (!rst_n_i)
    (tick_i && !pins_i.as && !mode) |=> !chain_q.d4_n)
    else $error("stage c not set while bus idle");

endmodule

// ==== dram_access_refresh_sequencer.sv ====
// Top of the DRAM access and refresh sequencer for a 16-bit processor bus
// Functional notes
// R1 - Outputs active low except acknowledge enable; read/write input high reads; always-on outputs driven.
// R2 - Start row strobe on selected strobe, stage c, no cycle done, phase low.
// R3 - Hidden refresh row strobe when unselected, stage a set, enabled.
// R4 - Hold row strobe while selected with strobe, or while stage a set.
// R5 - Set cycle done after stages a,b without c; hold while strobe asserted.
// R6 - Hold cycle done while phase low; ends on first rising phase edge.
// R7 - Set cycle done for strobed access elsewhere with all stages clear.
// R8 - Mark access during refresh when refresh mode meets address strobe.
// R9 - Keep that mark while stage c and address strobe both remain.
// R10 - Continue acknowledge on stage a, open row cycle, or write strobe.
// R11 - Write half of test-and-set starts a second stage a pulse.
// R12 - Enter refresh mode on idle request; hold until stages b and c set.
// R13 - Enter refresh mode during long accesses to other devices.
// R14 - Stage a set by refresh, access start, hold, or wait lengthening.
// R15 - Stage b follows a without c; stage c follows b or idle or forced.
// R16 - Acknowledge only while selected; wait input adds one wait state.
// R17 - System ties hidden refresh enable low to disable hidden refresh.
// R18 - Mode and stages step on register clock; others follow inputs.
`timescale 1ns/1ps
module dram_access_refresh_sequencer
  import dram_seq_pkg::*;
(
  input wire logic mclk_i,                   // System clock, 50 MHz
  input wire logic rst_n_i,                  // Asynchronous reset
  input wire logic reg_clk_i,                // Register clock for the chain
  input wire logic clk_phase_i,              // Processor clock phase
  input wire logic cs_n_i,                   // Chip select
  input wire logic as_n_i,                   // Address strobe
  input wire logic refresh_request_in_n_i,   // Refresh request
  input wire logic byte_data_strobe_n_i,     // Data strobe
  input wire logic rd_wr_i,                  // High read, low write
  input wire logic hidden_refresh_enable_i,  // Low disables hidden refresh
  input wire logic wait_n_i,                 // Insert one wait state
  output logic row_strobe_request_n_o,       // Row strobe request
  output logic refresh_mode_n_o,             // Forced refresh mode select
  output logic transfer_acknowledge_n_o,     // Transfer acknowledge
  output logic transfer_acknowledge_oe_o,    // Acknowledge pin driven
  output logic cycle_done_n_o,               // Cycle tracking
  output logic access_during_refresh_n_o,    // Access began in refresh
  output logic delay_stage_a_n_o,            // Delay stage a
  output logic delay_stage_b_n_o,            // Delay stage b
  output logic delay_stage_c_n_o             // Delay stage c
);

  // Reset release through two flops
  logic [1:0] rst_pipe_q;
  logic [1:0] rst_pipe_d;
  logic rst_sync_n;

  always_comb begin
    rst_pipe_d = {rst_pipe_q[0], 1'b1};
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe_q <= RST_PIPE_RST;
    end else begin
      rst_pipe_q <= rst_pipe_d;
    end
  end

  assign rst_sync_n = rst_pipe_q[1];

  // Pin polarity is corrected ahead of the synchroniser
  pins_type pins_raw;
  pins_type pins;

  always_comb begin
    pins_raw.cs = ~cs_n_i;
    pins_raw.as = ~as_n_i;
    pins_raw.refresh_req = ~refresh_request_in_n_i;
    pins_raw.byte_strobe = ~byte_data_strobe_n_i;
    pins_raw.rd = rd_wr_i; // R1
    pins_raw.hre = hidden_refresh_enable_i;
    pins_raw.clk_phase = clk_phase_i;
    pins_raw.wait_req = ~wait_n_i;
    pins_raw.reg_clk = reg_clk_i;
  end

  pin_sync #(
    .WIDTH(PINS_W),
    .IDLE(PINS_IDLE)
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_sync_n),
    .d_i(pins_raw),
    .q_o(pins)
  );

  // Register clock edge; the chain only moves on its rising edge
  logic reg_clk_prev_q;
  logic reg_clk_prev_d;
  logic tick;

  always_comb begin
    reg_clk_prev_d = pins.reg_clk;
  end

  always_ff @(posedge mclk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_clk_prev_q <= 1'b0;
    end else begin
      reg_clk_prev_q <= reg_clk_prev_d;
    end
  end

  assign tick = pins.reg_clk & ~reg_clk_prev_q; // R18

  // Feedback outputs, stored active low except the acknowledge enable, so each port is a flop
  logic row_req_n_q;
  logic cyc_n_q;
  logic in_refresh_n_q;
  logic ack_n_q;
  logic ack_oe_q;
  logic row_req_n_d;
  logic cyc_n_d;
  logic in_refresh_n_d;
  logic ack_n_d;
  logic ack_oe_d;
  chain_type chain;
  logic row_req;
  logic cyc;
  logic in_refresh;
  logic ack;
  logic mode;
  logic d2;
  logic d3;
  logic d4;
  logic ack_new;
  logic ack_hold;

  delay_chain u_delay_chain (
    .mclk_i(mclk_i),
    .rst_n_i(rst_sync_n),
    .tick_i(tick),
    .pins_i(pins),
    .row_req_i(row_req),
    .cyc_i(cyc),
    .in_refresh_i(in_refresh),
    .chain_o(chain)
  );

  always_comb begin
    row_req = ~row_req_n_q;
    cyc = ~cyc_n_q;
    in_refresh = ~in_refresh_n_q;
    ack = ~ack_n_q;
    mode = ~chain.mode_n;
    d2 = ~chain.d2_n;
    d3 = ~chain.d3_n;
    d4 = ~chain.d4_n;
  end

  // Combinational sequencer terms, registered once on the system clock
  always_comb begin
    row_req_n_d = ~(
      (pins.cs & pins.as & ~mode & d4 & ~cyc & ~pins.clk_phase) | // R2
      (~pins.cs & ~in_refresh & pins.as & ~mode & d2 & ~cyc &
       pins.hre) | // R3 R17
      (pins.cs & row_req & ~mode & pins.as) | // R4
      (row_req & ~mode & d2)); // R4
    cyc_n_d = ~(
      (~mode & d2 & d3 & ~d4) | // R5
      (cyc & pins.as) | // R5
      (~mode & cyc & ~pins.clk_phase) | // R6
      (~pins.cs & pins.as & ~mode & ~d2 & ~d3 & ~d4)); // R7
    in_refresh_n_d = ~(
      (mode & pins.as) | // R8
      (in_refresh & d4 & pins.as)); // R9
    // Reads wait on the data strobe, writes on the address strobe
    ack_new = ~mode & ~pins.clk_phase &
              ((pins.as & ~pins.rd) | (pins.byte_strobe & pins.rd)) &
              (~pins.wait_req | d2); // R16
    ack_hold = ack & ~mode &
               (d2 | (pins.as & row_req & ~cyc) |
                (pins.as & ~pins.rd)); // R10
    // Undriven pin reads back inactive, so the hold cannot outlive select
    ack_n_d = ~(pins.cs & (ack_new | ack_hold)); // R16
    ack_oe_d = pins.cs; // R16
  end

  always_ff @(posedge mclk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      row_req_n_q <= OUT_IDLE_N;
      cyc_n_q <= OUT_IDLE_N;
      in_refresh_n_q <= OUT_IDLE_N;
      ack_n_q <= OUT_IDLE_N;
      ack_oe_q <= 1'b0;
    end else begin
      row_req_n_q <= row_req_n_d;
      cyc_n_q <= cyc_n_d;
      in_refresh_n_q <= in_refresh_n_d;
      ack_n_q <= ack_n_d;
      ack_oe_q <= ack_oe_d;
    end
  end

  // Always-on outputs, active low except the acknowledge enable
  assign row_strobe_request_n_o = row_req_n_q; // R1
  assign cycle_done_n_o = cyc_n_q;
  assign access_during_refresh_n_o = in_refresh_n_q;
  assign transfer_acknowledge_n_o = ack_n_q;
  assign transfer_acknowledge_oe_o = ack_oe_q;
  assign refresh_mode_n_o = chain.mode_n;
  assign delay_stage_a_n_o = chain.d2_n;
  assign delay_stage_b_n_o = chain.d3_n;
  assign delay_stage_c_n_o = chain.d4_n;

  a_row_start: assert property ( // R2
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (pins.cs && pins.as && !mode && d4 && !cyc && !pins.clk_phase)
    |=> !row_strobe_request_n_o)
    else $error("row strobe request did not start for an access");

  a_hidden_refresh: assert property ( // R3
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (!pins.cs && !in_refresh && pins.as && !mode && d2 && !cyc && pins.hre)
    |=> !row_strobe_request_n_o)
    else $error("hidden refresh row strobe missing");

  a_row_quiet: assert property ( // R4
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (mode || (!pins.as && !d2)) |=> row_strobe_request_n_o)
    else $error("row strobe request active without cause");

  a_cycle_hold: assert property ( // R5
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (cyc && pins.as) |=> !cycle_done_n_o)
    else $error("cycle done dropped while address strobe held");

  a_cycle_end: assert property ( // R6
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (cyc && !pins.as && pins.clk_phase && !(!mode && d2 && d3 && !d4) &&
     !(!pins.cs && pins.as)) |=> cycle_done_n_o)
    else $error("cycle done did not end on rising clock phase");

  a_other_access: assert property ( // R7
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (!pins.cs && pins.as && !mode && !d2 && !d3 && !d4)
    |=> !cycle_done_n_o)
    else $error("cycle done missing for access to another device");

  a_refresh_mark: assert property ( // R8
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (mode && pins.as) |=> !access_during_refresh_n_o)
    else $error("access during refresh not recorded");

  a_mark_release: assert property ( // R9
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (!pins.as) |=> access_during_refresh_n_o)
    else $error("access during refresh held without address strobe");

  a_ack_continue: assert property ( // R10
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (ack && pins.cs && !mode && d2) |=> !transfer_acknowledge_n_o)
    else $error("transfer acknowledge not continued on stage a");

  a_ack_select: assert property ( // R16
    @(posedge mclk_i) disable iff (!rst_sync_n)
    !pins.cs |=> (transfer_acknowledge_n_o && !transfer_acknowledge_oe_o))
    else $error("transfer acknowledge driven without chip select");

  a_ack_wait: assert property ( // R16
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (!ack && pins.wait_req && !d2) |=> transfer_acknowledge_n_o)
    else $error("wait state not inserted before acknowledge");

  a_ack_write: assert property ( // R16
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (pins.cs && pins.as && !pins.rd && !mode && !pins.clk_phase &&
     !pins.wait_req) |=> !transfer_acknowledge_n_o)
    else $error("write not acknowledged without wait");

  a_ack_read: assert property ( // R16
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (pins.cs && pins.byte_strobe && pins.rd && !mode && !pins.clk_phase &&
     d2) |=> !transfer_acknowledge_n_o)
    else $error("read not acknowledged after wait state");

  a_ack_rmw: assert property ( // R10
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (ack && pins.cs && !mode && pins.as && !pins.rd)
    |=> !transfer_acknowledge_n_o)
    else $error("transfer acknowledge dropped in write cycle");

  a_ack_open_row: assert property ( // R10
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (ack && pins.cs && !mode && pins.as && row_req && !cyc)
    |=> !transfer_acknowledge_n_o)
    else $error("transfer acknowledge dropped with row strobe open");

  a_ack_refresh: assert property ( // R16
    @(posedge mclk_i) disable iff (!rst_sync_n)
    mode |=> transfer_acknowledge_n_o)
    else $error("transfer acknowledge given during refresh mode");

  a_row_hold: assert property ( // R4
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (row_req && !mode && d2) |=> !row_strobe_request_n_o)
    else $error("row strobe request dropped while stage a set");

  a_cycle_set: assert property ( // R5
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (!mode && d2 && d3 && !d4) |=> !cycle_done_n_o)
    else $error("cycle done not set after stages a and b");

  a_cycle_phase: assert property ( // R6
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (cyc && !mode && !pins.clk_phase) |=> !cycle_done_n_o)
    else $error("cycle done dropped while clock phase low");

  a_mark_hold: assert property ( // R9
    @(posedge mclk_i) disable iff (!rst_sync_n)
    (in_refresh && d4 && pins.as) |=> !access_during_refresh_n_o)
    else $error("access during refresh dropped while stage c held");

endmodule

// ==== dram_far_side_model.sv ====
// Far side: processor clock phase, register clock and refresh requests
`timescale 1ns/1ps
module dram_far_side_model (
  input wire logic mclk_i,             // System clock
  input wire logic refresh_mode_n_i,   // Refresh mode from the block
  output logic reg_clk_o,              // Register clock
  output logic clk_phase_o,            // Processor clock phase
  output logic refresh_request_in_n_o  // Refresh request, active low
);
  logic [2:0] div_q;
  logic [1:0] ph_q;
  int gap_q;
  initial begin
    div_q = 3'h0;
    ph_q = 2'h0;
    gap_q = 40;
    reg_clk_o = 1'b0;
    clk_phase_o = 1'b0;
    refresh_request_in_n_o = 1'b1;
  end
  // Both clocks run free; each register clock level lasts 3 cycles
  always @(posedge mclk_i) begin
    #2;
    div_q = (div_q == 3'h5) ? 3'h0 : div_q + 3'h1;
    ph_q = ph_q + 2'h1;
    reg_clk_o = (div_q > 3'h2);
    clk_phase_o = ph_q[1];
    // Request is held until forced refresh mode answers it
    if (refresh_request_in_n_o == 1'b0 && refresh_mode_n_i == 1'b0) begin
      refresh_request_in_n_o = 1'b1;
      gap_q = $urandom_range(90, 20);
    end else if (gap_q > 0) begin
      gap_q = gap_q - 1;
    end else begin
      refresh_request_in_n_o = 1'b0;
    end
  end
endmodule

// ==== dram_access_refresh_sequencer_tb.sv ====
// Self-checking bench for the DRAM access and refresh sequencer
`timescale 1ns/1ps
module dram_access_refresh_sequencer_tb
  import dram_seq_pkg::*;
();
  logic mclk_i, rst_n_i, cs_n, as_n, strb_n, rd_wr, hre, wait_n;
  logic rclk, ph, req_n, live;
  logic rs_n, md_n, ak_n, oe_o, cy_n, ir_n, a_n, b_n, c_n;
  logic md, a, b, c, rs, cy, ir, ak, oe, prc, f;
  logic [1:0] mr;
  pins_type pin, s1, s;
  logic [8:0] exp_v, seen_v, note_v;
  logic [8:0] notes[$];
  int err_count, checked, cyc_cnt;

  initial mclk_i = 1'b0;
  always #10 mclk_i = ~mclk_i;

  dram_access_refresh_sequencer i_dram_access_refresh_sequencer (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_clk_i(rclk),
    .clk_phase_i(ph), .cs_n_i(cs_n), .as_n_i(as_n),
    .refresh_request_in_n_i(req_n), .byte_data_strobe_n_i(strb_n),
    .rd_wr_i(rd_wr), .hidden_refresh_enable_i(hre), .wait_n_i(wait_n),
    .row_strobe_request_n_o(rs_n), .refresh_mode_n_o(md_n),
    .transfer_acknowledge_n_o(ak_n), .transfer_acknowledge_oe_o(oe_o),
    .cycle_done_n_o(cy_n), .access_during_refresh_n_o(ir_n),
    .delay_stage_a_n_o(a_n), .delay_stage_b_n_o(b_n),
    .delay_stage_c_n_o(c_n));

  dram_far_side_model i_dram_far_side_model (
    .mclk_i(mclk_i), .refresh_mode_n_i(md_n), .reg_clk_o(rclk),
    .clk_phase_o(ph), .refresh_request_in_n_o(req_n));

  // Reference model: two sync stages, then registered outputs
  assign pin = {~cs_n, ~as_n, ~req_n, ~strb_n, rd_wr, hre, ph, ~wait_n, rclk};
  assign f = ~s.cs & s.refresh_req & s.as & cy & ~a & ~b & ~rs;
  always @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i) mr <= 2'h0;
    else mr <= {mr[0], 1'b1};
  always @(posedge mclk_i or negedge mr[1]) begin
    if (!mr[1]) begin
      s1 <= PINS_IDLE;
      s <= PINS_IDLE;
      {prc, md, a, b, c, rs, cy, ir, ak, oe} <= '0;
    end else begin
      s1 <= pin;
      s <= s1;
      prc <= s.reg_clk;
      rs <= s.cs & s.as & ~md & c & ~cy & ~s.clk_phase
        | ~s.cs & ~ir & s.as & ~md & a & ~cy & s.hre
        | s.cs & rs & ~md & s.as | rs & ~md & a;
      cy <= ~md & a & b & ~c | cy & s.as
        | ~md & cy & ~s.clk_phase
        | ~s.cs & s.as & ~md & ~a & ~b & ~c;
      ir <= md & s.as | ir & c & s.as;
      ak <= s.cs & (~md & ~s.clk_phase & (~s.wait_req | a)
        & (s.as & ~s.rd | s.byte_strobe & s.rd)
        | ak & ~md & (a | s.as & rs & ~cy | s.as & ~s.rd));
      oe <= s.cs;
      if (s.reg_clk & ~prc) begin
        md <= s.refresh_req & ~s.as & ~cy & ~rs | f
          | md & ~b | md & ~c;
        a <= md & ~c | s.as & ~cy & ~md & ~b & c & (~ir | s.cs)
          | ~md & a & ~b | s.cs & s.wait_req & s.as & ~md & a & b & ~c
          | s.cs & s.as & ~s.rd & cy & ~md & ~a & ~b & ~c;
        b <= a & ~c;
        c <= b | ~s.as & ~md | f & ~md;
      end
    end
  end

  assign exp_v = {~rs, ~md, ~ak, oe, ~cy, ~ir, ~a, ~b, ~c};
  assign seen_v = {rs_n, md_n, ak_n, oe_o, cy_n, ir_n, a_n, b_n, c_n};
  always @(negedge mclk_i) if (live) notes.push_back(exp_v);
  always @(negedge mclk_i) begin
    #1;
    if (notes.size() > 0) begin
      note_v = notes.pop_front();
      checked++;
      if (seen_v !== note_v) begin
        err_count++;
        $display("Error outputs expected %h seen %h", note_v, seen_v);
      end
    end
  end

  // Bits of v: cs, as, rd, data strobe, wait, hidden refresh enable
  task automatic drive(input logic [5:0] v, input int n);
    {cs_n, as_n, rd_wr, strb_n, wait_n, hre} =
      {~v[5], ~v[4], v[3], ~v[2], ~v[1], v[0]};
    repeat (n) @(posedge mclk_i);
    #2;
  endtask

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Cuts a hang short well above the expected run of about 7000 cycles
  initial cyc_cnt = 0;
  always @(posedge mclk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    err_count = 0;
    checked = 0;
    live = 1'b0;
    rst_n_i = 1'b0;
    drive(6'h00, 20);
    rst_n_i = 1'b1;
    live = 1'b1;
    void'($urandom(32'h689c));
    drive(6'h00, 10);
    drive(6'h30, 24);
    drive(6'h00, 12);
    drive(6'h3e, 24);
    drive(6'h00, 12);
    drive(6'h3c, 16);
    drive(6'h30, 16);
    drive(6'h00, 12);
    drive(6'h11, 60);
    drive(6'h10, 60);
    drive(6'h00, 12);
    // Random bus traffic meets refresh requests at every phase
    repeat (1500) drive(6'($urandom), $urandom_range(8, 1));
    rst_n_i = 1'b0;
    drive(6'h33, 3);
    rst_n_i = 1'b1;
    drive(6'h00, 20);
    summarize();
  end
endmodule
